// *** hdl/nvma_pkg.sv ***
// Constants, encodings and carrier types for the nonvolatile access block
package nvma_pkg;

  // ----------------------------------------------------------------------
  // Widths and address map
  // ----------------------------------------------------------------------
  localparam int          DATA_W        = 14;
  localparam int          BYTE_W        = 8;
  localparam int          ADDR_W        = 15;
  localparam logic [14:0] PROG_LAST     = 15'h3fff;
  localparam logic [14:0] PROG_SPLIT    = 15'h2000;
  localparam logic [14:0] UID_LAST      = 15'h0003;
  localparam logic [14:0] REV_ID_ADDR   = 15'h0005;
  localparam logic [14:0] DEV_ID_ADDR   = 15'h0006;
  localparam logic [14:0] CFG_FIRST     = 15'h0007;
  localparam logic [14:0] CFG_LAST      = 15'h000b;
  localparam logic [14:0] CFG_PROT_ADDR = 15'h000b;
  localparam logic [14:0] DIA_FIRST     = 15'h0100;
  localparam logic [14:0] DIA_LAST      = 15'h02ff;
  localparam logic [14:0] DATA_FIRST    = 15'h7000;
  localparam logic [14:0] DATA_LAST     = 15'h70ff;
  localparam int          IND_PROG_BIT  = 15;

  // ----------------------------------------------------------------------
  // Protection word layout and write-protect regions
  // ----------------------------------------------------------------------
  localparam int          PROT_PCP_BIT  = 0;
  localparam int          PROT_DCP_BIT  = 1;
  localparam int          PROT_WRT_LSB  = 2;
  localparam int          WRT_REGIONS   = 4;
  localparam int          WRT_LOW       = 0;
  localparam int          WRT_HIGH      = 1;
  localparam int          WRT_CFG       = 2;
  localparam int          WRT_DATA      = 3;

  // ----------------------------------------------------------------------
  // Internal write timer
  // ----------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          WRITE_TIME_NS = 50000;
  localparam int          ERASE_TIME_NS = 100000;
  localparam int          TMR_W         = 12;
  localparam logic [11:0] WRITE_CYC     =
    TMR_W'((WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] ERASE_CYC     =
    TMR_W'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {COP_READ, COP_WRITE, COP_ERASE} nvma_cop_e;
  typedef enum logic [1:0] {POP_READ, POP_WRITE, POP_BULK} nvma_pop_e;
  typedef enum logic [1:0] {SP_PROG, SP_CFG, SP_DATA} nvma_space_e;
  typedef enum logic [2:0] {M_NONE, M_READ, M_WRITE, M_ROW_ERASE,
                            M_ERASE_WRITE, M_BULK} nvma_mop_e;
  typedef enum logic [2:0] {C_PROG, C_UID, C_RO, C_CFG, C_DATA,
                            C_NONE} nvma_cls_e;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic              indirect;
    nvma_cop_e         op;
    logic              memory_space_select;
    logic [15:0]       addr;
    logic [13:0]       wdata;
  } nvma_cpu_req_s;

  typedef struct packed {
    logic              valid;
    nvma_pop_e         op;
    nvma_space_e       target;
    logic [14:0]       addr;
    logic [13:0]       wdata;
  } nvma_prg_req_s;

  typedef struct packed {
    nvma_mop_e         op;
    nvma_space_e       space;
    logic [2:0]        bulk_mask;
    logic [14:0]       addr;
    logic [13:0]       wdata;
  } nvma_mem_cmd_s;

  typedef struct packed {
    logic              done;
    logic              denied;
    logic [13:0]       rdata;
  } nvma_rsp_s;

  typedef struct packed {
    logic [3:0]        region_write_protect_n;
    logic              data_flash_code_protect_n;
    logic              program_flash_code_protect_n;
  } nvma_prot_s;

  localparam nvma_prot_s PROT_RESET   = 6'h00;
  localparam nvma_prot_s PROT_ERASED  = 6'h3f;

endpackage

// *** hdl/nvma_timer.sv ***
// Down-counting timer that paces every nonvolatile write and erase
`timescale 1ns/1ps
`default_nettype none
module nvma_timer (
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic                  start,
  input  wire logic [11:0]           load,
  output logic                       done
);
  import nvma_pkg::*;

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic        done_q;
  logic        done_d;

  // ----------------------------------------------------------------------
  // Count
  // ----------------------------------------------------------------------
  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = load;
    end else if (cnt_q != 12'h000) begin
      cnt_d  = cnt_q - 12'h001;
      done_d = (cnt_q == 12'h001);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_q  <= 12'h000;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;

endmodule
`default_nettype wire

// *** hdl/nvma_ctrl.sv ***
// Nonvolatile memory access and protection controller
`timescale 1ns/1ps
`default_nettype none
module nvma_ctrl (
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire nvma_pkg::nvma_cpu_req_s cpu_req,
  input  wire nvma_pkg::nvma_prg_req_s prg_req,
  input  wire nvma_pkg::nvma_prot_s  prot_strap,
  input  wire logic                  write_error_clear,
  input  wire logic [13:0]           mem_rdata,
  output nvma_pkg::nvma_rsp_s        cpu_rsp,
  output nvma_pkg::nvma_rsp_s        prg_rsp,
  output nvma_pkg::nvma_mem_cmd_s    mem_cmd,
  output nvma_pkg::nvma_prot_s       prot,
  output logic                       write_error_flag,
  output logic                       busy
);
  import nvma_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_RCMD, S_RDATA, S_BUSY} nvma_state_e;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  function automatic nvma_cls_e classify(input nvma_cpu_req_s r);
    logic [14:0] a;
    a = r.addr[14:0];
    if (r.indirect) begin
      if (r.addr[IND_PROG_BIT])
        classify = (a <= PROG_LAST) ? C_PROG : C_NONE;
      else if (a >= DATA_FIRST && a <= DATA_LAST)
        classify = C_DATA;
      else
        classify = C_NONE;
    end else if (!r.memory_space_select) begin
      classify = (a <= PROG_LAST) ? C_PROG : C_NONE;
    end else if (a <= UID_LAST) begin
      classify = C_UID;
    end else if (a == REV_ID_ADDR || a == DEV_ID_ADDR) begin
      classify = C_RO;
    end else if (a >= CFG_FIRST && a <= CFG_LAST) begin
      classify = C_CFG;
    end else if (a >= DIA_FIRST && a <= DIA_LAST) begin
      classify = C_RO;
    end else if (a >= DATA_FIRST && a <= DATA_LAST) begin
      classify = C_DATA;
    end else begin
      classify = C_NONE;
    end
  endfunction

  function automatic nvma_space_e space_of(input nvma_cls_e c);
    unique case (c)
      C_PROG:  space_of = SP_PROG;
      C_DATA:  space_of = SP_DATA;
      default: space_of = SP_CFG;
    endcase
  endfunction

  function automatic logic wp_hit(input nvma_cls_e c, input logic [14:0] a,
                                  input nvma_prot_s p);
    unique case (c)
      C_PROG:  wp_hit = (a < PROG_SPLIT) ? !p.region_write_protect_n[WRT_LOW]
                                         : !p.region_write_protect_n[WRT_HIGH];
      C_UID,
      C_CFG:   wp_hit = !p.region_write_protect_n[WRT_CFG];
      C_DATA:  wp_hit = !p.region_write_protect_n[WRT_DATA];
      default: wp_hit = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  nvma_state_e   state_q, state_d;
  logic          owner_q, owner_d;
  nvma_mem_cmd_s cmd_q, cmd_d;
  nvma_rsp_s     cpu_rsp_q, cpu_rsp_d;
  nvma_rsp_s     prg_rsp_q, prg_rsp_d;
  nvma_prot_s    prot_q, prot_d;
  logic          werr_q, werr_d;
  logic          loaded_q, loaded_d;
  logic          busy_q, busy_d;
  logic          tmr_start;
  logic [11:0]   tmr_load;
  logic          tmr_done;
  nvma_cls_e     cls;
  logic          prg_take;
  logic          cpu_take;
  logic          prg_locked;
  logic          werr_set;

  assign cls        = classify(cpu_req);
  assign prg_take   = loaded_q && !busy_q && prg_req.valid;
  assign cpu_take   = loaded_q && !busy_q && cpu_req.valid && !prg_req.valid;
  assign prg_locked = (prg_req.target == SP_PROG &&
                       !prot_q.program_flash_code_protect_n) ||
                      (prg_req.target == SP_DATA &&
                       !prot_q.data_flash_code_protect_n);

  always_comb begin
    state_d          = state_q;
    owner_d          = owner_q;
    cmd_d            = '0;
    cmd_d.op         = M_NONE;
    cpu_rsp_d        = cpu_rsp_q;
    cpu_rsp_d.done   = 1'b0;
    cpu_rsp_d.denied = 1'b0;
    prg_rsp_d        = prg_rsp_q;
    prg_rsp_d.done   = 1'b0;
    prg_rsp_d.denied = 1'b0;
    prot_d           = prot_q;
    loaded_d         = 1'b1;
    werr_set         = 1'b0;
    tmr_start        = 1'b0;
    tmr_load         = WRITE_CYC;
    if (!loaded_q)
      prot_d = prot_strap;
    unique case (state_q)
      S_IDLE: begin
        if (prg_take) begin
          owner_d    = 1'b1;
          cmd_d.addr = prg_req.addr;
          cmd_d.space = prg_req.target;
          unique case (prg_req.op)
            POP_READ: begin
              if (prg_locked) begin
                prg_rsp_d.done   = 1'b1;
                prg_rsp_d.denied = 1'b1;
                prg_rsp_d.rdata  = 14'h0000;
              end else begin
                cmd_d.op = M_READ;
                state_d  = S_RCMD;
              end
            end
            POP_WRITE: begin
              if (prg_locked) begin
                prg_rsp_d.done   = 1'b1;
                prg_rsp_d.denied = 1'b1;
              end else begin
                cmd_d.op    = (prg_req.target == SP_DATA) ? M_ERASE_WRITE
                                                          : M_WRITE;
                cmd_d.wdata = (prg_req.target == SP_DATA)
                            ? {6'h00, prg_req.wdata[BYTE_W-1:0]}
                            : prg_req.wdata;
                if (prg_req.target == SP_CFG && prg_req.addr == CFG_PROT_ADDR)
                  prot_d = prot_q & prg_req.wdata[5:0];
                tmr_start = 1'b1;
                state_d   = S_BUSY;
              end
            end
            default: begin
              cmd_d.op        = M_BULK;
              cmd_d.bulk_mask = 3'h1 << prg_req.target;
              if (prg_req.target == SP_CFG) begin
                if (!prot_q.program_flash_code_protect_n ||
                    !prot_q.data_flash_code_protect_n)
                  cmd_d.bulk_mask = 3'h7;
                prot_d = PROT_ERASED;
              end
              tmr_load  = ERASE_CYC;
              tmr_start = 1'b1;
              state_d   = S_BUSY;
            end
          endcase
        end else if (cpu_take) begin
          owner_d     = 1'b0;
          cmd_d.addr  = cpu_req.addr[14:0];
          cmd_d.space = space_of(cls);
          if (cpu_req.op == COP_READ) begin
            if (cls == C_NONE) begin
              cpu_rsp_d.done  = 1'b1;
              cpu_rsp_d.rdata = 14'h0000;
            end else begin
              cmd_d.op = M_READ;
              state_d  = S_RCMD;
            end
          end else if (cpu_req.indirect) begin
            cpu_rsp_d.done = 1'b1;
          end else if (cls == C_NONE || cls == C_RO ||
                       wp_hit(cls, cpu_req.addr[14:0], prot_q) ||
                       (cpu_req.op == COP_ERASE &&
                        cls != C_PROG && cls != C_UID)) begin
            cpu_rsp_d.done   = 1'b1;
            cpu_rsp_d.denied = 1'b1;
            werr_set         = 1'b1;
          end else begin
            if (cpu_req.op == COP_ERASE) begin
              cmd_d.op = M_ROW_ERASE;
              tmr_load = ERASE_CYC;
            end else if (cls == C_DATA) begin
              cmd_d.op    = M_ERASE_WRITE;
              cmd_d.wdata = {6'h00, cpu_req.wdata[BYTE_W-1:0]};
            end else begin
              cmd_d.op    = M_WRITE;
              cmd_d.wdata = cpu_req.wdata;
            end
            if (cls == C_CFG && cpu_req.op == COP_WRITE &&
                cpu_req.addr[14:0] == CFG_PROT_ADDR)
              prot_d = prot_q & cpu_req.wdata[5:0];
            tmr_start = 1'b1;
            state_d   = S_BUSY;
          end
        end
      end
      S_RCMD: begin
        state_d = S_RDATA;
      end
      S_RDATA: begin
        if (owner_q) begin
          prg_rsp_d.done  = 1'b1;
          prg_rsp_d.rdata = mem_rdata;
        end else begin
          cpu_rsp_d.done  = 1'b1;
          cpu_rsp_d.rdata = mem_rdata;
        end
        state_d = S_IDLE;
      end
      S_BUSY: begin
        if (tmr_done) begin
          prg_rsp_d.done = owner_q;
          cpu_rsp_d.done = !owner_q;
          state_d        = S_IDLE;
        end
      end
    endcase
    werr_d = werr_set || (werr_q && !write_error_clear);
    busy_d = (state_d != S_IDLE) || !loaded_d;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q   <= S_IDLE;
      owner_q   <= 1'b0;
      cmd_q     <= '0;
      cpu_rsp_q <= '0;
      prg_rsp_q <= '0;
      prot_q    <= PROT_RESET;
      werr_q    <= 1'b0;
      loaded_q  <= 1'b0;
      busy_q    <= 1'b1;
    end else begin
      state_q   <= state_d;
      owner_q   <= owner_d;
      cmd_q     <= cmd_d;
      cpu_rsp_q <= cpu_rsp_d;
      prg_rsp_q <= prg_rsp_d;
      prot_q    <= prot_d;
      werr_q    <= werr_d;
      loaded_q  <= loaded_d;
      busy_q    <= busy_d;
    end
  end

  nvma_timer u_timer (
    .clock (clock),
    .srst  (srst),
    .start (tmr_start),
    .load  (tmr_load),
    .done  (tmr_done)
  );

  assign cpu_rsp          = cpu_rsp_q;
  assign prg_rsp          = prg_rsp_q;
  assign mem_cmd          = cmd_q;
  assign prot             = prot_q;
  assign write_error_flag = werr_q;
  assign busy             = busy_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [11:0] busy_len_q;
  logic [11:0] busy_exp_q;
  always_ff @(posedge clock) begin
    busy_len_q <= (state_d != S_BUSY) ? 12'h000 :
                  (state_q == S_BUSY) ? busy_len_q + 12'h001 : 12'h001;
    if (tmr_start)
      busy_exp_q <= tmr_load;
  end

  dflash_autoerase_a: assert property (@(posedge clock) disable iff (srst)
    cmd_q.space == SP_DATA && cmd_q.op inside {M_WRITE, M_ROW_ERASE}
    |-> 1'b0) else $error("data flash written without auto-erase");
  dflash_byte_a: assert property (@(posedge clock) disable iff (srst)
    cmd_q.space == SP_DATA && cmd_q.op == M_ERASE_WRITE
    |-> cmd_q.wdata[13:8] == 6'h00)
    else $error("data flash write wider than a byte");
  timer_length_a: assert property (@(posedge clock) disable iff (srst)
    state_q == S_BUSY && tmr_done |-> busy_len_q == busy_exp_q + 12'h001)
    else $error("write time not set by internal timer");
  cp_deny_a: assert property (@(posedge clock) disable iff (srst)
    prg_take && prg_locked && prg_req.op != POP_BULK
    |=> prg_rsp.done && prg_rsp.denied && cmd_q.op == M_NONE)
    else $error("protected memory reached by programmer");
  wp_block_a: assert property (@(posedge clock) disable iff (srst)
    cpu_take && cpu_req.op != COP_READ &&
    wp_hit(cls, cpu_req.addr[14:0], prot_q)
    |=> cmd_q.op == M_NONE) else $error("protected region written");
  werr_set_a: assert property (@(posedge clock) disable iff (srst)
    cpu_take && !cpu_req.indirect && cpu_req.op != COP_READ &&
    wp_hit(cls, cpu_req.addr[14:0], prot_q)
    |=> write_error_flag ##1 (write_error_flag || $past(write_error_clear)))
    else $error("write error flag not raised");
  prot_clear_a: assert property (@(posedge clock) disable iff (srst)
    $past(loaded_q) && (prot_q & ~$past(prot_q)) != 6'h00
    |-> $past(cmd_d.op) == M_BULK && $past(prg_req.target) == SP_CFG)
    else $error("protection cleared outside bulk erase");
  bulk_source_a: assert property (@(posedge clock) disable iff (srst)
    cmd_q.op == M_BULK |-> $past(prg_take) && $past(prg_req.op) == POP_BULK)
    else $error("bulk erase without programmer request");
  bulk_all_a: assert property (@(posedge clock) disable iff (srst)
    prg_take && prg_req.op == POP_BULK && prg_req.target == SP_CFG &&
    !prot_q.program_flash_code_protect_n |=> cmd_q.bulk_mask == 3'h7)
    else $error("protected config bulk erase left regions");
  prog_end_a: assert property (@(posedge clock) disable iff (srst)
    cpu_take && cpu_req.op == COP_READ && !cpu_req.indirect &&
    !cpu_req.memory_space_select && cpu_req.addr[14:0] > PROG_LAST
    |=> cpu_rsp.done && cpu_rsp.rdata == 14'h0000 && cmd_q.op == M_NONE)
    else $error("read past program flash end");
  ind_read_a: assert property (@(posedge clock) disable iff (srst)
    cpu_take && cpu_req.indirect && cpu_req.op == COP_READ && cls == C_PROG
    |=> cmd_q.op == M_READ && cmd_q.space == SP_PROG ##2 cpu_rsp.done)
    else $error("indirect program read mishandled");
  ro_area_a: assert property (@(posedge clock) disable iff (srst)
    cpu_take && cpu_req.op != COP_READ && cls == C_RO
    |=> cmd_q.op == M_NONE && cpu_rsp.denied)
    else $error("read-only area written");
  ind_write_a: assert property (@(posedge clock) disable iff (srst)
    cpu_take && cpu_req.indirect && cpu_req.op != COP_READ
    |=> cmd_q.op == M_NONE && cpu_rsp.done && !cpu_rsp.denied)
    else $error("indirect write reached memory");

endmodule
`default_nettype wire

// *** dv/nvma_mem_model.sv ***
// Behavioural word store that answers the controller's memory port
`timescale 1ns/1ps
`default_nettype none
module nvma_mem_model (
  input  wire logic                   clock,
  input  wire nvma_pkg::nvma_mem_cmd_s mem_cmd,
  output logic [13:0]                 mem_rdata
);
  import nvma_pkg::*;
  logic [13:0] store [logic [16:0]];
  logic [16:0] key;

  initial mem_rdata = 14'h0000;

  // Read data is only valid for one cycle, it toggles otherwise
  always @(posedge clock) begin
    key = {mem_cmd.space, mem_cmd.addr};
    mem_rdata <= ~mem_rdata;
    case (mem_cmd.op)
      M_READ: begin
        mem_rdata <= store.exists(key) ? store[key] : 14'h3fff;
      end
      M_WRITE, M_ERASE_WRITE: begin
        store[key] = mem_cmd.wdata;
      end
      M_ROW_ERASE: begin
        for (int i = 0; i < 32; i++) store[{key[16:5], 5'(i)}] = 14'h3fff;
      end
      M_BULK: begin
        foreach (store[k]) if (mem_cmd.bulk_mask[k[16:15]]) store[k] = 14'h3fff;
      end
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvma_pkg::*;
  logic          clock             = 1'b0;
  logic          srst              = 1'b1;
  nvma_cpu_req_s cpu_req           = '0;
  nvma_prg_req_s prg_req           = '0;
  nvma_prot_s    prot_strap        = PROT_ERASED;
  logic          write_error_clear = 1'b0;
  logic [13:0]   mem_rdata;
  nvma_rsp_s     cpu_rsp, prg_rsp, rsp;
  nvma_mem_cmd_s mem_cmd, cmd1;
  nvma_prot_s    prot;
  logic          write_error_flag, busy;
  int            fail_count = 0, total_checks = 0, cyc;
  logic [13:0]   wd;
  logic [14:0]   ad;

  always #12.5 clock = ~clock;

  nvma_ctrl nvma_ctrl_inst (
    .clock(clock), .srst(srst), .cpu_req(cpu_req), .prg_req(prg_req),
    .prot_strap(prot_strap), .write_error_clear(write_error_clear),
    .mem_rdata(mem_rdata), .cpu_rsp(cpu_rsp), .prg_rsp(prg_rsp),
    .mem_cmd(mem_cmd), .prot(prot), .write_error_flag(write_error_flag),
    .busy(busy));
  nvma_mem_model nvma_mem_model_inst (
    .clock(clock), .mem_cmd(mem_cmd), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------------
  // Checking and request tasks
  // ----------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cyc(input int got, input int exp, input string what);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("BAD %0t %s took %0d want %0d", $time, what, got, exp);
    end
  endtask

  // One request, held for the taking edge, then wait for its answer
  task automatic run(input bit p, input logic ind, input logic [1:0] op,
                     input nvma_space_e tg, input logic [15:0] a,
                     input logic [13:0] d);
    int lim;
    lim = 0;
    do begin
      @(negedge clock);
      lim++;
    end while (busy !== 1'b0 && lim < 10);
    if (busy !== 1'b0) begin
      fail_count++;
      $display("BAD %0t still busy", $time);
      complete_run();
    end
    if (p) prg_req = '{1'b1, nvma_pop_e'(op), tg, a[14:0], d};
    else cpu_req = '{1'b1, ind, nvma_cop_e'(op), tg != SP_PROG, a, d};
    @(negedge clock);
    cpu_req.valid = 1'b0;
    prg_req.valid = 1'b0;
    cmd1 = mem_cmd;
    chk_val(busy, cmd1.op != M_NONE, "busy after take");
    cyc = 1;
    rsp = p ? prg_rsp : cpu_rsp;
    while (rsp.done !== 1'b1 && cyc < 5000) begin
      @(negedge clock);
      cyc++;
      rsp = p ? prg_rsp : cpu_rsp;
    end
    if (cyc >= 5000) begin
      fail_count++;
      $display("BAD %0t no answer", $time);
      complete_run();
    end
    chk_val(busy, 0, "busy at done");
  endtask

  task automatic clear_err();
    write_error_clear = 1'b1;
    @(negedge clock);
    write_error_clear = 1'b0;
    chk_val(write_error_flag, 0, "flag clear");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    wd = 14'($urandom(32'had8d13ed));
    repeat (16) @(negedge clock);
    srst = 1'b0;
    repeat (2) @(negedge clock);
    chk_val(prot, PROT_ERASED, "strap");
    for (int i = 0; i < 4; i++) begin
      ad = (i == 0) ? PROG_LAST : 15'($urandom_range(0, 16'h3fff));
      wd = 14'($urandom);
      run(0, 0, COP_WRITE, SP_PROG, {1'b0, ad}, wd);
      chk_cyc(cyc, int'(WRITE_CYC) + 2, "write time");
      run(0, 0, COP_READ, SP_PROG, {1'b0, ad}, 14'h0000);
      chk_cyc(cyc, 3, "read time");
      chk_val(rsp.rdata, wd, "read back");
      run(0, 1, COP_READ, SP_PROG, {1'b1, ad}, 14'h0000);
      chk_val(rsp.rdata, wd, "ind read");
      run(0, 1, COP_WRITE, SP_PROG, {1'b1, ad}, ~wd);
      chk_val(cmd1.op, M_NONE, "ind write");
      chk_val(write_error_flag, 0, "ind flag");
      run(0, 0, COP_READ, SP_PROG, {1'b0, ad}, 14'h0000);
      chk_val(rsp.rdata, wd, "kept");
    end
    run(0, 0, COP_ERASE, SP_PROG, {1'b0, ad}, 14'h0000);
    chk_cyc(cyc, int'(ERASE_CYC) + 2, "erase time");
    run(0, 1, COP_READ, SP_PROG, 16'h0005, 14'h0000);
    chk_val(rsp.rdata, 0, "ind other");
    run(0, 0, COP_READ, SP_PROG, 16'h4000, 14'h0000);
    chk_val(rsp.rdata, 0, "past end");
    run(0, 0, COP_WRITE, SP_PROG, 16'h4000, wd);
    chk_val(rsp.denied, 1, "past end w");
    clear_err();
    ad = DATA_FIRST + 15'($urandom_range(0, 255));
    run(0, 0, COP_WRITE, SP_DATA, {1'b0, ad}, 14'h3fa5);
    chk_val(cmd1.op, M_ERASE_WRITE, "byte op");
    chk_val(cmd1.wdata, 14'h00a5, "byte data");
    run(0, 0, COP_READ, SP_DATA, {1'b0, ad}, 14'h0000);
    chk_val(rsp.rdata, 14'h00a5, "byte read");
    run(0, 0, COP_ERASE, SP_DATA, {1'b0, ad}, 14'h0000);
    chk_val(rsp.denied, 1, "data erase");
    clear_err();
    for (int j = 0; j < 4; j++) begin
      ad = j == 0 ? REV_ID_ADDR : j == 1 ? DEV_ID_ADDR
         : j == 2 ? DIA_FIRST : DIA_LAST;
      run(0, 0, COP_WRITE, SP_CFG, {1'b0, ad}, wd);
      chk_val({rsp.denied, write_error_flag}, 2'b11, "read only");
      clear_err();
    end
    run(0, 0, COP_WRITE, SP_CFG, {1'b0, UID_LAST}, wd);
    chk_val(rsp.denied, 0, "user id");
    run(0, 0, COP_WRITE, SP_CFG, {1'b0, CFG_PROT_ADDR}, 14'h003a);
    chk_val(prot, 6'h3a, "protect");
    run(0, 0, COP_WRITE, SP_PROG, 16'h0010, wd);
    chk_val({rsp.denied, write_error_flag}, 2'b11, "wp write");
    clear_err();
    run(0, 0, COP_WRITE, SP_PROG, {1'b0, PROG_SPLIT}, wd);
    chk_val(rsp.denied, 0, "self write");
    run(1, 0, POP_READ, SP_PROG, {1'b0, PROG_SPLIT}, 14'h0000);
    chk_val({rsp.denied, rsp.rdata}, 15'h4000, "cp read");
    run(1, 0, POP_WRITE, SP_PROG, {1'b0, PROG_SPLIT}, wd);
    chk_val(rsp.denied, 1, "cp write");
    run(1, 0, POP_READ, SP_DATA, {1'b0, DATA_FIRST}, 14'h0000);
    chk_val(rsp.denied, 0, "data open");
    run(1, 0, POP_WRITE, SP_DATA, {1'b0, DATA_FIRST}, 14'h3f5a);
    chk_val(cmd1.op, M_ERASE_WRITE, "prg byte op");
    chk_val(cmd1.wdata, 14'h005a, "prg byte data");
    run(0, 0, COP_WRITE, SP_CFG, {1'b0, CFG_PROT_ADDR}, 14'h3fff);
    chk_val(prot, 6'h3a, "no unprotect");
    run(1, 0, POP_BULK, SP_CFG, 16'h0000, 14'h0000);
    chk_val(cmd1.bulk_mask, 3'h7, "bulk all");
    chk_cyc(cyc, int'(ERASE_CYC) + 2, "bulk time");
    chk_val(prot, PROT_ERASED, "bulk clears");
    run(0, 0, COP_READ, SP_PROG, {1'b0, PROG_SPLIT}, 14'h0000);
    chk_val(rsp.rdata, 14'h3fff, "wiped");
    run(1, 0, POP_BULK, SP_CFG, 16'h0000, 14'h0000);
    chk_val(cmd1.bulk_mask, 3'h2, "bulk cfg");
    srst = 1'b1;
    prot_strap = 6'h3c;
    repeat (16) @(negedge clock);
    srst = 1'b0;
    repeat (2) @(negedge clock);
    chk_val(prot, 6'h3c, "strap again");
    run(1, 0, POP_READ, SP_DATA, {1'b0, DATA_FIRST}, 14'h0000);
    chk_val(rsp.denied, 1, "data locked");
    complete_run();
  end
endmodule
`default_nettype wire
